// File: cac_pkg.sv
// constants and types of the codec mode and overflow control register
package cac_pkg;

	// register address on the host register port
	localparam logic [5:0] CAC_MODE_OVF_OFFS = 6'h06;
	localparam logic [15:0] CAC_MODE_OVF_RESET = 16'h0000;
	// bits that software may change: 15..9 and 5..3
	localparam logic [15:0] CAC_WR_MASK = 16'hfe38;
	// revision code, value arbitrary
	localparam logic [2:0] CAC_REV_ID = 3'h1;
	// touch ADC clock divider per reference rate, plain defaults
	localparam logic [7:0] CAC_TSC_DIV_48K = 8'h0c;
	localparam logic [7:0] CAC_TSC_DIV_44K = 8'h0b;
	// flag index inside the overflow vector
	localparam int CAC_OVF_ADC = 2;
	localparam int CAC_OVF_DACL = 1;
	localparam int CAC_OVF_DACR = 0;

	typedef enum logic [1:0] {
		CAC_VOL_INDEP = 2'h0,
		CAC_VOL_R2L = 2'h1,
		CAC_VOL_L2R = 2'h2,
		CAC_VOL_INDEP2 = 2'h3
	} cac_vol_link_t;

	// register image, msb first
	typedef struct packed {
		cac_vol_link_t dac_volume_link_select;
		logic reference_rate_select;
		logic transfer_mode_select;
		logic codec_role_select;
		logic phone_input_diff_select;
		logic phone_output_diff_select;
		logic adc_overflow_flag;
		logic dac_left_overflow_flag;
		logic dac_right_overflow_flag;
		logic [1:0] reserved;
		logic agc_clip_step_control;
		logic [2:0] silicon_revision_field;
	} cac_reg_t;

	// settings derived from the reference rate
	typedef struct packed {
		logic deemphCoefSel;
		logic agcTimeConstSel;
		logic [7:0] tscClkDiv;
	} cac_rate_cfg_t;

endpackage

// File: cac_overflow_flag.sv
// sticky saturation flag, cleared by a register read, set wins
`timescale 1ns/10ps
module cac_overflow_flag (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// event and clear
	input wire logic satEvent,
	input wire logic readClear,
	// flag
	output logic flag_q
);
	import cac_pkg::*;

	logic flag_d;

	always_comb begin
		flag_d = flag_q;
		if (readClear) begin
			flag_d = 1'b0;
		end
		if (satEvent) begin
			flag_d = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	a_event_sets_flag: assert property (satEvent |=> flag_q)
		else $error("saturation event did not set flag");
	a_clear_drops_flag: assert property (
		readClear && !satEvent |=> !flag_q)
		else $error("read did not clear flag");
	a_flag_holds: assert property (
		flag_q && !readClear |=> flag_q)
		else $error("flag dropped without a read");

endmodule // cac_overflow_flag

// File: cac_volume_link.sv
// applies the left/right DAC volume linking
`timescale 1ns/10ps
module cac_volume_link (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// link mode and programmed volumes
	input wire cac_pkg::cac_vol_link_t linkSel,
	input wire logic [6:0] leftVolProg,
	input wire logic [6:0] rightVolProg,
	// volumes applied to the channels
	output logic [6:0] leftVolApplied_q,
	output logic [6:0] rightVolApplied_q
);
	import cac_pkg::*;

	logic [6:0] leftVol_d;
	logic [6:0] rightVol_d;

	always_comb begin
		leftVol_d = leftVolProg;
		rightVol_d = rightVolProg;
		case (linkSel)
			CAC_VOL_R2L: begin
				leftVol_d = rightVolProg;
			end
			CAC_VOL_L2R: begin
				rightVol_d = leftVolProg;
			end
			CAC_VOL_INDEP, CAC_VOL_INDEP2: begin
				leftVol_d = leftVolProg;
			end
			default: begin
				leftVol_d = leftVolProg;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			leftVolApplied_q <= 7'h00;
			rightVolApplied_q <= 7'h00;
		end else begin
			leftVolApplied_q <= leftVol_d;
			rightVolApplied_q <= rightVol_d;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	a_vol_indep: assert property (
		linkSel == CAC_VOL_INDEP || linkSel == CAC_VOL_INDEP2
		|=> leftVolApplied_q == $past(leftVolProg)
		&& rightVolApplied_q == $past(rightVolProg))
		else $error("independent volumes not kept apart");
	a_vol_r2l: assert property (
		linkSel == CAC_VOL_R2L
		|=> leftVolApplied_q == $past(rightVolProg)
		&& rightVolApplied_q == $past(rightVolProg))
		else $error("right volume not applied to left");
	a_vol_l2r: assert property (
		linkSel == CAC_VOL_L2R
		|=> rightVolApplied_q == $past(leftVolProg)
		&& leftVolApplied_q == $past(leftVolProg))
		else $error("left volume not applied to right");

endmodule // cac_volume_link

// File: cac_mode_ovf_ctrl.sv
// codec mode and overflow control register with its decoded outputs
`timescale 1ns/10ps
module cac_mode_ovf_ctrl (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// host register port
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [5:0] regAddr,
	input wire logic [15:0] regWrData,
	output logic [15:0] regRdData_q,
	output logic regRdValid_q,
	// saturation events from the datapath
	input wire logic adcSatEvent,
	input wire logic dacLeftSatEvent,
	input wire logic dacRightSatEvent,
	// programmed channel volumes and AGC state
	input wire logic [6:0] leftVolProg,
	input wire logic [6:0] rightVolProg,
	input wire logic agcSelected,
	// applied volumes
	output logic [6:0] leftVolApplied_q,
	output logic [6:0] rightVolApplied_q,
	// mode outputs and overflow flags
	output cac_pkg::cac_rate_cfg_t rateCfg_q,
	output logic transferMode256_q,
	output logic codecMaster_q,
	output logic phoneInputDiff_q,
	output logic phoneOutputDiff_q,
	output logic clipStepActive_q,
	output logic [2:0] ovfFlags_q
);
	import cac_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// register decode

	logic regHit;
	logic rdTake;
	logic wrTake;
	cac_reg_t wrImage;

	assign regHit = (regAddr == CAC_MODE_OVF_OFFS);
	assign rdTake = regRdEn && regHit;
	assign wrTake = regWrEn && regHit;
	assign wrImage = cac_reg_t'(regWrData);

	////////////////////////////////////////////////////////////////////////
	// writable fields

	cac_reg_t ctrl_q;
	cac_reg_t ctrl_d;

	always_comb begin
		ctrl_d = ctrl_q;
		if (wrTake) begin
			ctrl_d = cac_reg_t'((regWrData & CAC_WR_MASK)
				| (16'(ctrl_q) & ~CAC_WR_MASK));
		end
		ctrl_d.adc_overflow_flag = 1'b0;
		ctrl_d.dac_left_overflow_flag = 1'b0;
		ctrl_d.dac_right_overflow_flag = 1'b0;
		ctrl_d.silicon_revision_field = 3'h0;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl_q <= cac_reg_t'(CAC_MODE_OVF_RESET);
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// overflow flags

	logic [2:0] satEvents;

	assign satEvents[CAC_OVF_ADC] = adcSatEvent;
	assign satEvents[CAC_OVF_DACL] = dacLeftSatEvent;
	assign satEvents[CAC_OVF_DACR] = dacRightSatEvent;

	// same flag logic for left DAC
	// same flag logic for right DAC
	for (genvar i = 0; i < 3; i++) begin : g_ovf
		cac_overflow_flag u_flag (
			.mclk(mclk),
			.srst(srst),
			.satEvent(satEvents[i]),
			.readClear(rdTake),
			.flag_q(ovfFlags_q[i])
		);
	end

	////////////////////////////////////////////////////////////////////////
	// read path

	cac_reg_t rdImage;
	logic [15:0] rdData_d;
	logic rdValid_d;

	always_comb begin
		rdImage = ctrl_q;
		rdImage.adc_overflow_flag = ovfFlags_q[CAC_OVF_ADC];
		rdImage.dac_left_overflow_flag = ovfFlags_q[CAC_OVF_DACL];
		rdImage.dac_right_overflow_flag = ovfFlags_q[CAC_OVF_DACR];
		rdImage.silicon_revision_field = CAC_REV_ID;
		rdData_d = regRdData_q;
		rdValid_d = rdTake;
		if (rdTake) begin
			rdData_d = 16'(rdImage);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			regRdData_q <= 16'h0000;
			regRdValid_q <= 1'b0;
		end else begin
			regRdData_q <= rdData_d;
			regRdValid_q <= rdValid_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// volume linking

	cac_volume_link u_vol (
		.mclk(mclk),
		.srst(srst),
		.linkSel(ctrl_q.dac_volume_link_select),
		.leftVolProg(leftVolProg),
		.rightVolProg(rightVolProg),
		.leftVolApplied_q(leftVolApplied_q),
		.rightVolApplied_q(rightVolApplied_q)
	);

	////////////////////////////////////////////////////////////////////////
	// decoded mode outputs

	cac_rate_cfg_t rateCfg_d;
	logic transferMode256_d;
	logic codecMaster_d;
	logic phoneInputDiff_d;
	logic phoneOutputDiff_d;
	logic clipStepActive_d;

	always_comb begin
		// rate picks filter, AGC and touch divider sets
		rateCfg_d.deemphCoefSel = ctrl_q.reference_rate_select;
		rateCfg_d.agcTimeConstSel = ctrl_q.reference_rate_select;
		rateCfg_d.tscClkDiv = ctrl_q.reference_rate_select
			? CAC_TSC_DIV_44K : CAC_TSC_DIV_48K;
		transferMode256_d = ctrl_q.transfer_mode_select;
		codecMaster_d = ctrl_q.codec_role_select;
		phoneInputDiff_d = ctrl_q.phone_input_diff_select;
		phoneOutputDiff_d = ctrl_q.phone_output_diff_select;
		// clip stepping gated by AGC use
		clipStepActive_d = ctrl_q.agc_clip_step_control && agcSelected;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			rateCfg_q <= '{deemphCoefSel: 1'b0, agcTimeConstSel: 1'b0,
				tscClkDiv: CAC_TSC_DIV_48K};
			transferMode256_q <= 1'b0;
			codecMaster_q <= 1'b0;
			phoneInputDiff_q <= 1'b0;
			phoneOutputDiff_q <= 1'b0;
			clipStepActive_q <= 1'b0;
		end else begin
			rateCfg_q <= rateCfg_d;
			transferMode256_q <= transferMode256_d;
			codecMaster_q <= codecMaster_d;
			phoneInputDiff_q <= phoneInputDiff_d;
			phoneOutputDiff_q <= phoneOutputDiff_d;
			clipStepActive_q <= clipStepActive_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	// read image view used by the checks
	cac_reg_t rdSeen;

	assign rdSeen = cac_reg_t'(regRdData_q);

	// write, then the mode output follows two edges later
	sequence s_role_write(logic v);
		wrTake && wrImage.codec_role_select == v;
	endsequence

	sequence s_read_back(logic ev);
		rdTake && !ev ##1 regRdValid_q;
	endsequence

	a_rate_divider: assert property (
		##1 rateCfg_q.tscClkDiv == ($past(ctrl_q.reference_rate_select)
		? CAC_TSC_DIV_44K : CAC_TSC_DIV_48K)
		&& rateCfg_q.deemphCoefSel == $past(ctrl_q.reference_rate_select))
		else $error("rate settings do not follow the rate bit");
	a_xfer_mode: assert property (
		wrTake |-> ##2 transferMode256_q
		== $past(wrImage.transfer_mode_select, 2))
		else $error("transfer mode did not follow write");
	a_role_master: assert property (
		s_role_write(1'b1) |-> ##2 codecMaster_q)
		else $error("master role not taken");
	a_role_slave: assert property (
		s_role_write(1'b0) |-> ##2 !codecMaster_q)
		else $error("slave role not taken");
	a_phone_diff: assert property (
		wrTake |-> ##2 phoneInputDiff_q
		== $past(wrImage.phone_input_diff_select, 2)
		&& phoneOutputDiff_q == $past(wrImage.phone_output_diff_select, 2))
		else $error("phone path select did not follow write");
	a_adc_read_clear: assert property (
		s_read_back(adcSatEvent) |-> !ovfFlags_q[CAC_OVF_ADC])
		else $error("ADC flag survived a read");
	a_dacl_read_clear: assert property (
		s_read_back(dacLeftSatEvent) |-> !ovfFlags_q[CAC_OVF_DACL])
		else $error("left DAC flag survived a read");
	a_dacr_read_clear: assert property (
		s_read_back(dacRightSatEvent) |-> !ovfFlags_q[CAC_OVF_DACR])
		else $error("right DAC flag survived a read");
	a_dacl_visible: assert property (
		ovfFlags_q[CAC_OVF_DACL] && rdTake
		|=> regRdData_q[7] && regRdValid_q)
		else $error("left DAC flag not seen by read");
	a_dacr_set_wins: assert property (
		dacRightSatEvent && rdTake |=> ovfFlags_q[CAC_OVF_DACR])
		else $error("right DAC event lost during read clear");
	a_clip_gate: assert property (
		!agcSelected |=> !clipStepActive_q)
		else $error("clip stepping active without AGC");
	a_rev_read: assert property (
		rdTake |=> regRdData_q[2:0] == CAC_REV_ID)
		else $error("revision field wrong");
	a_ro_write: assert property (
		wrTake && !adcSatEvent && !ovfFlags_q[CAC_OVF_ADC]
		|=> !ovfFlags_q[CAC_OVF_ADC])
		else $error("write changed a read-only flag");
	a_rsvd_store: assert property (
		wrTake |=> ctrl_q.reserved == $past(wrImage.reserved))
		else $error("reserved bits did not store write");
	// flags seen by a read are the ones from before the clear
	a_rd_flag_image: assert property (
		rdTake |=> rdSeen.adc_overflow_flag
		== $past(ovfFlags_q[CAC_OVF_ADC])
		&& rdSeen.dac_left_overflow_flag
		== $past(ovfFlags_q[CAC_OVF_DACL])
		&& rdSeen.dac_right_overflow_flag
		== $past(ovfFlags_q[CAC_OVF_DACR]))
		else $error("read image flags wrong");
	a_rate_agc: assert property (
		1'b1 |=> rateCfg_q.agcTimeConstSel
		== $past(ctrl_q.reference_rate_select))
		else $error("AGC time constant does not follow the rate bit");
	a_clip_on: assert property (
		ctrl_q.agc_clip_step_control && agcSelected |=> clipStepActive_q)
		else $error("clip stepping not enabled with AGC");
	a_wr_mask: assert property (
		wrTake |=> 16'(ctrl_q) == ($past(regWrData) & CAC_WR_MASK))
		else $error("write did not store the writable bits");
	// stored bits only move on a taken write
	a_ctrl_hold: assert property (
		!wrTake |=> ctrl_q == $past(ctrl_q))
		else $error("control bits changed without a write");
	// writes must never reach the sticky flags
	a_ovf_write_hold: assert property (
		wrTake && !rdTake && satEvents == 3'h0
		|=> ovfFlags_q == $past(ovfFlags_q))
		else $error("write disturbed the overflow flags");
	a_rd_valid_hit: assert property (
		!rdTake |=> !regRdValid_q)
		else $error("read valid without a taken read");

endmodule // cac_mode_ovf_ctrl

// File: testbench.sv
// self-checking testbench of the codec mode and overflow control register
`timescale 1ns/10ps
module testbench;
	import cac_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [5:0] regAddr = 6'h00;
	logic [15:0] regWrData = 16'h0000;
	logic [15:0] regRdData_q;
	logic regRdValid_q;
	logic [2:0] satEv = 3'h0;
	logic [6:0] leftVolProg = 7'h00;
	logic [6:0] rightVolProg = 7'h00;
	logic agcSelected = 1'b0;
	logic [6:0] leftVolApplied_q;
	logic [6:0] rightVolApplied_q;
	cac_rate_cfg_t rateCfg_q;
	logic transferMode256_q;
	logic codecMaster_q;
	logic phoneInputDiff_q;
	logic phoneOutputDiff_q;
	logic clipStepActive_q;
	logic [2:0] ovfFlags_q;
	logic [15:0] rdExp[$];
	logic [15:0] wrImg = 16'h0000;
	logic [2:0] ovfExp = 3'h0;
	int n_mismatch = 0;
	int n_checks = 0;

	always #2 mclk = ~mclk;

	cac_mode_ovf_ctrl u_cac_mode_ovf_ctrl (
		.mclk(mclk), .srst(srst),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
		.regWrData(regWrData), .regRdData_q(regRdData_q),
		.regRdValid_q(regRdValid_q),
		.adcSatEvent(satEv[2]), .dacLeftSatEvent(satEv[1]),
		.dacRightSatEvent(satEv[0]),
		.leftVolProg(leftVolProg), .rightVolProg(rightVolProg),
		.agcSelected(agcSelected),
		.leftVolApplied_q(leftVolApplied_q),
		.rightVolApplied_q(rightVolApplied_q),
		.rateCfg_q(rateCfg_q), .transferMode256_q(transferMode256_q),
		.codecMaster_q(codecMaster_q), .phoneInputDiff_q(phoneInputDiff_q),
		.phoneOutputDiff_q(phoneOutputDiff_q),
		.clipStepActive_q(clipStepActive_q), .ovfFlags_q(ovfFlags_q)
	);

	////////////////////////////////////////////////////////////////////
	task automatic miss(input logic [15:0] got, input logic [15:0] exp);
		n_mismatch++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
	endtask

	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
			miss(got, exp);
	endtask

	task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
			miss(got, exp);
	endtask

	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic reg_wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge mclk);
		#1;
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		if (a == CAC_MODE_OVF_OFFS)
			wrImg = d & CAC_WR_MASK;
		@(posedge mclk);
		#1;
		regWrEn = 1'b0;
	endtask

	task automatic reg_rd(input logic [5:0] a);
		@(posedge mclk);
		#1;
		regRdEn = 1'b1;
		regAddr = a;
		if (a == CAC_MODE_OVF_OFFS) begin
			rdExp.push_back(wrImg | {7'h0, ovfExp, 6'h0} | {13'h0, CAC_REV_ID});
			ovfExp = 3'h0;
		end
		@(posedge mclk);
		#1;
		regRdEn = 1'b0;
	endtask

	task automatic wait2;
		repeat (2) @(posedge mclk);
		#1;
	endtask

	task automatic check_modes(input logic [15:0] w);
		logic [15:0] e;
		e = {1'b0, w[13], w[13], w[13] ? CAC_TSC_DIV_44K : CAC_TSC_DIV_48K,
			w[12], w[11], w[10], w[9], w[3] & agcSelected};
		chk_val({1'b0, rateCfg_q, transferMode256_q, codecMaster_q,
			phoneInputDiff_q, phoneOutputDiff_q,
			clipStepActive_q}, e);
	endtask

	task automatic pulse(input logic [2:0] m);
		@(posedge mclk);
		#1;
		satEv = m;
		ovfExp = ovfExp | m;
		@(posedge mclk);
		#1;
		satEv = 3'h0;
	endtask

	task automatic do_reset;
		@(posedge mclk);
		#1;
		srst = 1'b1;
		wrImg = 16'h0000;
		ovfExp = 3'h0;
		repeat (3) @(posedge mclk);
		#1;
		srst = 1'b0;
	endtask

	// read result monitor
	always @(negedge mclk) begin
		if (regRdValid_q === 1'b1) begin
			if (rdExp.size() == 0)
				miss(regRdData_q, 16'h0000);
			else
				chk_rd(regRdData_q, rdExp.pop_front());
		end
	end

	initial begin
		repeat (20000) @(posedge mclk);
		miss(16'h0000, 16'h0001);
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////
	initial begin
		logic [15:0] w;
		logic [1:0] c;
		logic [6:0] el;
		logic [6:0] er;
		logic [2:0] masks[4];
		masks = '{3'h4, 3'h2, 3'h1, 3'h7};
		void'($urandom(32'h8bbd));
		repeat (3) @(posedge mclk);
		#1;
		srst = 1'b0;
		check_modes(16'h0000);
		reg_rd(CAC_MODE_OVF_OFFS);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			// bench rate stays at or below 48 kHz
			w = (i == 0) ? 16'hffff : 16'($urandom);
			agcSelected = (i == 0) ? 1'b1 : 1'($urandom);
			reg_wr(CAC_MODE_OVF_OFFS, w);
			wait2();
			check_modes(w);
			reg_rd(CAC_MODE_OVF_OFFS);
		end
		reg_wr(6'h07, 16'h0000);
		reg_rd(6'h05);
		reg_rd(CAC_MODE_OVF_OFFS);
		$display("test fields done");
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			leftVolProg = 7'($urandom);
			rightVolProg = 7'($urandom);
			reg_wr(CAC_MODE_OVF_OFFS, {c, 14'h0});
			wait2();
			el = (c == CAC_VOL_R2L) ? rightVolProg : leftVolProg;
			er = (c == CAC_VOL_L2R) ? leftVolProg : rightVolProg;
			chk_val({2'h0, leftVolApplied_q, rightVolApplied_q},
				{2'h0, el, er});
		end
		$display("test volume done");
		for (int i = 0; i < 4; i++) begin
			pulse(masks[i]);
			pulse(masks[i]);
			chk_val({13'h0, ovfFlags_q},
				{13'h0, ovfExp});
			reg_wr(CAC_MODE_OVF_OFFS, 16'hffff);
			reg_rd(CAC_MODE_OVF_OFFS);
			chk_val({13'h0, ovfFlags_q}, 16'h0000);
			reg_rd(CAC_MODE_OVF_OFFS);
		end
		// read and events in one cycle: set wins over the clear
		@(posedge mclk);
		#1;
		regRdEn = 1'b1;
		regAddr = CAC_MODE_OVF_OFFS;
		satEv = 3'h7;
		rdExp.push_back(wrImg | {13'h0, CAC_REV_ID});
		ovfExp = 3'h7;
		@(posedge mclk);
		#1;
		regRdEn = 1'b0;
		satEv = 3'h0;
		chk_val({13'h0, ovfFlags_q},
			{13'h0, ovfExp});
		reg_rd(CAC_MODE_OVF_OFFS);
		$display("test overflow done");
		pulse(3'h7);
		do_reset();
		check_modes(16'h0000);
		reg_rd(CAC_MODE_OVF_OFFS);
		$display("test second reset done");
		for (int i = 0; i < 20 && rdExp.size() != 0; i++)
			@(posedge mclk);
		if (rdExp.size() != 0)
			miss(16'(rdExp.size()), 16'h0000);
		print_verdict();
	end
endmodule // testbench
